// [design/cgh_core.sv]
// Host port command engine with pattern generator addressing
`timescale 1ns/1ps
`default_nettype none
module cgh_core
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [2:0]  busTypeStraps,
	input  wire logic        commandDataSelect,
	input  wire logic        rdPin,
	input  wire logic        wrPin,
	input  wire logic [7:0]  dataIn,
	output logic [7:0]       dataOut,
	output logic             dataOe,
	output logic [15:0]      memAddr,
	output logic [7:0]       memWrData,
	output logic             memWrEn,
	input  wire logic [7:0]  memRdData,
	input  wire logic        scanReq,
	input  wire logic [7:0]  scanCharCode,
	input  wire logic [3:0]  scanRow,
	output logic [15:0]      patternAddr,
	output logic             patternFromRam,
	output logic [7:0]       romPattern,
	output logic             patternValid,
	output logic [7:0]       displayConfig
);
	localparam int SYNC_W = 14;

	logic [SYNC_W-1:0] syncA_r;
	logic [SYNC_W-1:0] syncB_r;
	logic [SYNC_W-1:0] pinsRaw;

	logic [2:0]  busType;
	logic        selS;
	logic        rdS;
	logic        wrS;
	logic [7:0]  dataS;

	logic        cmdWrite;
	logic        dataWrite;
	logic        dataRead;
	logic        readLevel;

	cgh_pkg::cgh_state_type state_r;
	cgh_pkg::cgh_state_type state_nxt;
	logic [7:0]  regIdx_r;
	logic [7:0]  regIdx_nxt;
	logic [7:0]  config_r;
	logic [7:0]  config_nxt;
	logic [15:0] base_r;
	logic [15:0] base_nxt;
	logic [15:0] cursor_r;
	logic [15:0] cursor_nxt;
	logic [15:0] step_r;
	logic [15:0] step_nxt;
	logic [15:0] memAddr_r;
	logic [15:0] memAddr_nxt;
	logic [7:0]  memWrData_r;
	logic [7:0]  memWrData_nxt;
	logic        memWrEn_r;
	logic        memWrEn_nxt;
	logic [7:0]  dataOut_r;
	logic [7:0]  dataOut_nxt;

	// =========================================================
	// Pin synchronisers
	assign pinsRaw = {busTypeStraps, commandDataSelect, rdPin, wrPin, dataIn};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge clk_sys or negedge rstn)
			begin
				if (!rstn)
				begin
					syncA_r[gi] <= 1'b1;
					syncB_r[gi] <= 1'b1;
				end
				else
				begin
					syncA_r[gi] <= pinsRaw[gi];
					syncB_r[gi] <= syncA_r[gi];
				end
			end
		end
	endgenerate

	assign busType = syncB_r[13:11];
	assign selS    = syncB_r[10];
	assign rdS     = syncB_r[9];
	assign wrS     = syncB_r[8];
	assign dataS   = syncB_r[7:0];

	// =========================================================
	// Bus decode
	cgh_bus_decode u_decode
	(
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.busType   (busType),
		.selPin    (selS),
		.rdPin     (rdS),
		.wrPin     (wrS),
		.cmdWrite  (cmdWrite),
		.dataWrite (dataWrite),
		.dataRead  (dataRead),
		.readLevel (readLevel)
	);

	// =========================================================
	// Command and parameter engine
	always_comb
	begin
		state_nxt     = state_r;
		regIdx_nxt    = regIdx_r;
		config_nxt    = config_r;
		base_nxt      = base_r;
		cursor_nxt    = cursor_r;
		step_nxt      = step_r;
		memWrData_nxt = memWrData_r;
		memWrEn_nxt   = 1'b0;
		dataOut_nxt   = dataOut_r;
		if (cmdWrite)
		begin
			case (dataS)
				cgh_pkg::CMD_SYSTEM_SET:
				begin
					state_nxt  = cgh_pkg::ST_REGS;
					regIdx_nxt = cgh_pkg::REG_DISPLAY_CONFIG;
				end
				cgh_pkg::CMD_PATTERN_BASE:
				begin
					state_nxt  = cgh_pkg::ST_REGS;
					regIdx_nxt = cgh_pkg::REG_PATTERN_BASE_LOW;
				end
				cgh_pkg::CMD_CURSOR_LOAD:
					state_nxt = cgh_pkg::ST_CURSOR_LO;
				cgh_pkg::CMD_MEMORY_FILL:
					state_nxt = cgh_pkg::ST_FILL;
				cgh_pkg::CMD_CURSOR_RIGHT:
				begin
					step_nxt  = cgh_pkg::STEP_RIGHT;
					state_nxt = cgh_pkg::ST_IDLE;
				end
				cgh_pkg::CMD_CURSOR_LEFT:
				begin
					step_nxt  = cgh_pkg::STEP_LEFT;
					state_nxt = cgh_pkg::ST_IDLE;
				end
				default:
					state_nxt = cgh_pkg::ST_IDLE;
			endcase
		end
		else if (dataWrite)
		begin
			case (state_r)
				cgh_pkg::ST_REGS:
				begin
					regIdx_nxt = regIdx_r + 8'h01;
					case (regIdx_r)
						cgh_pkg::REG_DISPLAY_CONFIG:
						begin
							config_nxt = dataS;
							state_nxt  = cgh_pkg::ST_IDLE;
						end
						cgh_pkg::REG_PATTERN_BASE_LOW:
							base_nxt[7:0] = dataS;
						cgh_pkg::REG_PATTERN_BASE_HIGH:
						begin
							base_nxt[15:8] = dataS;
							state_nxt      = cgh_pkg::ST_IDLE;
						end
						default:
							state_nxt = cgh_pkg::ST_IDLE;
					endcase
				end
				cgh_pkg::ST_CURSOR_LO:
				begin
					cursor_nxt[7:0] = dataS;
					state_nxt       = cgh_pkg::ST_CURSOR_HI;
				end
				cgh_pkg::ST_CURSOR_HI:
				begin
					cursor_nxt[15:8] = dataS;
					state_nxt        = cgh_pkg::ST_IDLE;
				end
				cgh_pkg::ST_FILL:
				begin
					memWrData_nxt = dataS;
					memWrEn_nxt   = 1'b1;
					cursor_nxt    = cursor_r + step_r;
				end
				default:
					state_nxt = cgh_pkg::ST_IDLE;
			endcase
		end
		else if (dataRead)
		begin
			// Display memory answers combinationally at the cursor address
			dataOut_nxt = memRdData;
			cursor_nxt  = cursor_r + step_r;
		end
		// Write address holds the pre-advance cursor for one cycle
		memAddr_nxt = memWrEn_nxt ? cursor_r : cursor_nxt;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r     <= cgh_pkg::ST_IDLE;
			regIdx_r    <= cgh_pkg::REG_DISPLAY_CONFIG;
			config_r    <= cgh_pkg::RST_DISPLAY_CONFIG;
			base_r      <= cgh_pkg::RST_PATTERN_BASE;
			cursor_r    <= cgh_pkg::RST_CURSOR;
			step_r      <= cgh_pkg::STEP_RIGHT;
			memAddr_r   <= cgh_pkg::RST_CURSOR;
			memWrData_r <= 8'h00;
			memWrEn_r   <= 1'b0;
			dataOut_r   <= 8'h00;
		end
		else
		begin
			state_r     <= state_nxt;
			regIdx_r    <= regIdx_nxt;
			config_r    <= config_nxt;
			base_r      <= base_nxt;
			cursor_r    <= cursor_nxt;
			step_r      <= step_nxt;
			memAddr_r   <= memAddr_nxt;
			memWrData_r <= memWrData_nxt;
			memWrEn_r   <= memWrEn_nxt;
			dataOut_r   <= dataOut_nxt;
		end
	end

	assign dataOut       = dataOut_r;
	assign dataOe        = readLevel;
	assign memAddr       = memAddr_r;
	assign memWrData     = memWrData_r;
	assign memWrEn       = memWrEn_r;
	assign displayConfig = config_r;

	// =========================================================
	// Pattern generator addressing
	cgh_pattern u_pattern
	(
		.clk_sys        (clk_sys),
		.rstn           (rstn),
		.scanReq        (scanReq),
		.scanCharCode   (scanCharCode),
		.scanRow        (scanRow),
		.patternBase    (base_r),
		.romOff         (config_r[cgh_pkg::CFG_ROM_OFF_BIT]),
		.lines16        (config_r[cgh_pkg::CFG_LINES16_BIT]),
		.patternAddr    (patternAddr),
		.patternFromRam (patternFromRam),
		.romPattern     (romPattern),
		.patternValid   (patternValid)
	);

	// =========================================================
	// Checks
	sequence s_base_low_taken;
		dataWrite && state_r == cgh_pkg::ST_REGS && regIdx_r == cgh_pkg::REG_PATTERN_BASE_LOW;
	endsequence

	a_base_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_base_low_taken |=> base_r[7:0] == $past(dataS) && regIdx_r == cgh_pkg::REG_PATTERN_BASE_HIGH)
		else $error("base low byte not loaded");
	a_base_high: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dataWrite && state_r == cgh_pkg::ST_REGS && regIdx_r == cgh_pkg::REG_PATTERN_BASE_HIGH)
		|=> base_r[15:8] == $past(dataS) && state_r == cgh_pkg::ST_IDLE)
		else $error("base high byte not loaded");
	a_cursor_right: assert property (@(posedge clk_sys) disable iff (!rstn)
		(cmdWrite && dataS == cgh_pkg::CMD_CURSOR_RIGHT) |=> step_r == 16'h0001)
		else $error("cursor direction not rightward");
	a_cursor_load: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dataWrite && state_r == cgh_pkg::ST_CURSOR_HI)
		|=> cursor_r == {$past(dataS), $past(cursor_r[7:0])})
		else $error("cursor not loaded low then high");
	a_fill_advance: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dataWrite && state_r == cgh_pkg::ST_FILL)
		|=> memWrEn && memAddr == $past(cursor_r) && memWrData == $past(dataS)
		&& cursor_r == $past(cursor_r) + $past(step_r) ##1 memAddr == cursor_r)
		else $error("fill write or cursor advance wrong");
	a_ignored_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!cmdWrite && !dataWrite && !dataRead)
		|=> $stable(state_r) && $stable(cursor_r) && $stable(base_r) && $stable(config_r))
		else $error("state changed without a decoded access");
endmodule
`default_nettype wire

// [design/cgh_pkg.sv]
// Package of constants and types for the character generator host port
// What this block does
// - Internal ROM supplies 160 fixed 5x7 characters
// - ROM characters mix with 64 pattern RAM characters
// - ROM glyphs padded blank up to 8x16 cell
// - Config bit 2 picks 8x8 or 8x16 RAM characters
// - With ROM selected, pattern RAM base anywhere
// - Fetch address is base plus code plus row
// - Short fonts: code bits 10..3, row 2..0
// - Tall fonts: code bits 11..4, row 3..0
// - Eight lines or fewer short, nine up tall
// - ROM mode: codes 80h-9Fh, E0h-FFh from RAM
// - Command 5Ch loads base, low then high
// - Command 4Ch makes cursor advance by one
// - Command 46h loads cursor, low then high
// - Bus straps choose how strobe pins decode
// - Generic bus strobe decoding of three functions
// - 6800-style bus decoding with enable high
// - 68000-style bus decoding with strobe low
package cgh_pkg;

	// =========================================================
	// Commands
	localparam logic [7:0] CMD_SYSTEM_SET    = 8'h40;
	localparam logic [7:0] CMD_PATTERN_BASE  = 8'h5C;
	localparam logic [7:0] CMD_CURSOR_RIGHT  = 8'h4C;
	localparam logic [7:0] CMD_CURSOR_LEFT   = 8'h4D;
	localparam logic [7:0] CMD_CURSOR_LOAD   = 8'h46;
	localparam logic [7:0] CMD_MEMORY_FILL   = 8'h42;

	// =========================================================
	// Register offsets, fields and reset values
	localparam logic [7:0] REG_DISPLAY_CONFIG    = 8'h00;
	localparam logic [7:0] REG_PATTERN_BASE_LOW  = 8'h19;
	localparam logic [7:0] REG_PATTERN_BASE_HIGH = 8'h1A;
	localparam int         CFG_ROM_OFF_BIT       = 0;
	localparam int         CFG_LINES16_BIT       = 2;
	localparam logic [7:0]  RST_DISPLAY_CONFIG   = 8'h00;
	localparam logic [15:0] RST_PATTERN_BASE     = 16'h0000;
	localparam logic [15:0] RST_CURSOR           = 16'h0000;
	localparam logic [15:0] STEP_RIGHT           = 16'h0001;
	localparam logic [15:0] STEP_LEFT            = 16'hFFFF;

	// =========================================================
	// Character code map
	localparam logic [7:0] ROM_LOW_FIRST  = 8'h20;
	localparam logic [7:0] RAM_LOW_FIRST  = 8'h80;
	localparam logic [7:0] RAM_LOW_LAST   = 8'h9F;
	localparam logic [7:0] RAM_HIGH_FIRST = 8'hE0;
	localparam logic [3:0] ROM_GLYPH_ROWS = 4'h7;

	// =========================================================
	// Types
	typedef enum logic [2:0]
	{
		BUS_GENERIC     = 3'h0,
		BUS_ENABLE      = 3'h1,
		BUS_BYTE_STROBE = 3'h2
	} cgh_bus_type;

	typedef enum logic [2:0]
	{
		ST_IDLE      = 3'h0,
		ST_REGS      = 3'h1,
		ST_CURSOR_LO = 3'h3,
		ST_CURSOR_HI = 3'h2,
		ST_FILL      = 3'h6
	} cgh_state_type;

endpackage

// [design/cgh_bus_decode.sv]
// Strobe decoder turning the three bus families into access pulses
`timescale 1ns/1ps
`default_nettype none
module cgh_bus_decode
(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic [2:0] busType,
	input  wire logic       selPin,
	input  wire logic       rdPin,
	input  wire logic       wrPin,
	output logic            cmdWrite,
	output logic            dataWrite,
	output logic            dataRead,
	output logic            readLevel
);
	logic active;
	logic dirRead;
	logic dirWrite;
	logic activePrev_r;
	logic activePrev_nxt;
	logic start;

	// =========================================================
	// Strobe interpretation per bus family
	always_comb
	begin
		active   = 1'b0;
		dirRead  = 1'b0;
		dirWrite = 1'b0;
		case (busType)
			cgh_pkg::BUS_ENABLE:
			begin
				active   = wrPin;
				dirRead  = rdPin;
				dirWrite = !rdPin;
			end
			cgh_pkg::BUS_BYTE_STROBE:
			begin
				active   = !wrPin;
				dirRead  = rdPin;
				dirWrite = !rdPin;
			end
			default:
			begin
				active   = !rdPin || !wrPin;
				dirRead  = !rdPin && wrPin;
				dirWrite = rdPin && !wrPin;
			end
		endcase
	end

	always_comb
	begin
		activePrev_nxt = active;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			activePrev_r <= 1'b0;
		else
			activePrev_r <= activePrev_nxt;
	end

	// Read with select low and both strobes low match no row
	assign start     = active && !activePrev_r;
	assign cmdWrite  = start && selPin && dirWrite;
	assign dataWrite = start && !selPin && dirWrite;
	assign dataRead  = start && selPin && dirRead;
	assign readLevel = active && selPin && dirRead;

	// =========================================================
	// Checks
	a_generic_cmd: assert property (@(posedge clk_sys) disable iff (!rstn)
		(busType == cgh_pkg::BUS_GENERIC && !activePrev_r && selPin && rdPin && !wrPin)
		|-> cmdWrite && !dataWrite && !dataRead)
		else $error("generic command write not decoded");
	a_enable_read: assert property (@(posedge clk_sys) disable iff (!rstn)
		(busType == cgh_pkg::BUS_ENABLE && !activePrev_r && wrPin && selPin && rdPin)
		|-> dataRead ##1 !dataRead)
		else $error("6800 read not a single pulse");
	a_strobe_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(busType == cgh_pkg::BUS_BYTE_STROBE && !activePrev_r && !wrPin && !selPin && !rdPin)
		|-> dataWrite && !cmdWrite)
		else $error("68000 data write not decoded");
	a_odd_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
		(busType == cgh_pkg::BUS_GENERIC && !rdPin && (wrPin ? !selPin : 1'b1))
		|-> !cmdWrite && !dataWrite && !dataRead)
		else $error("unlisted generic combination decoded");
endmodule
`default_nettype wire

// [design/cgh_pattern.sv]
// Pattern address former and internal pattern ROM
`timescale 1ns/1ps
`default_nettype none
module cgh_pattern
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        scanReq,
	input  wire logic [7:0]  scanCharCode,
	input  wire logic [3:0]  scanRow,
	input  wire logic [15:0] patternBase,
	input  wire logic        romOff,
	input  wire logic        lines16,
	output logic [15:0]      patternAddr,
	output logic             patternFromRam,
	output logic [7:0]       romPattern,
	output logic             patternValid
);
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic        fromRam_r;
	logic        fromRam_nxt;
	logic [7:0]  rom_r;
	logic [7:0]  rom_nxt;
	logic        valid_r;
	logic        valid_nxt;
	logic        ramCode;
	logic        romCode;
	logic [15:0] offset;

	// Glyph body stands in for the mask contents; five columns in bits 7..3
	function automatic logic [4:0] glyph_row(input logic [7:0] code, input logic [2:0] row);
		glyph_row = code[4:0] ^ {row, row[1:0]};
	endfunction

	// =========================================================
	// Code classification and address forming
	always_comb
	begin
		ramCode = (scanCharCode >= cgh_pkg::RAM_LOW_FIRST && scanCharCode <= cgh_pkg::RAM_LOW_LAST)
			|| (scanCharCode >= cgh_pkg::RAM_HIGH_FIRST);
		romCode = !romOff && !ramCode && scanCharCode >= cgh_pkg::ROM_LOW_FIRST;
		if (lines16)
			offset = {4'h0, scanCharCode, scanRow};
		else
			offset = {5'h00, scanCharCode, scanRow[2:0]};
		addr_nxt    = scanReq ? patternBase + offset : addr_r;
		fromRam_nxt = scanReq ? (romOff || ramCode) : fromRam_r;
		rom_nxt     = rom_r;
		if (scanReq)
		begin
			rom_nxt = 8'h00;
			if (romCode && scanRow < cgh_pkg::ROM_GLYPH_ROWS)
				rom_nxt = {glyph_row(scanCharCode, scanRow[2:0]), 3'h0};
		end
		valid_nxt = scanReq;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_r    <= 16'h0000;
			fromRam_r <= 1'b0;
			rom_r     <= 8'h00;
			valid_r   <= 1'b0;
		end
		else
		begin
			addr_r    <= addr_nxt;
			fromRam_r <= fromRam_nxt;
			rom_r     <= rom_nxt;
			valid_r   <= valid_nxt;
		end
	end

	assign patternAddr    = addr_r;
	assign patternFromRam = fromRam_r;
	assign romPattern     = rom_r;
	assign patternValid   = valid_r;

	// =========================================================
	// Checks
	a_addr_short: assert property (@(posedge clk_sys) disable iff (!rstn)
		(scanReq && !lines16) |=> patternAddr ==
		$past(patternBase) + {5'h00, $past(scanCharCode), $past(scanRow[2:0])})
		else $error("short font address wrong");
	a_addr_tall: assert property (@(posedge clk_sys) disable iff (!rstn)
		(scanReq && lines16) |=> patternAddr ==
		$past(patternBase) + {4'h0, $past(scanCharCode), $past(scanRow)})
		else $error("tall font address wrong");
	a_ram_codes: assert property (@(posedge clk_sys) disable iff (!rstn)
		(scanReq && !romOff && scanCharCode[7:5] == 3'h5) |=> !patternFromRam)
		else $error("ROM code taken from pattern RAM");
	a_rom_pad: assert property (@(posedge clk_sys) disable iff (!rstn)
		scanReq |=> romPattern[2:0] == 3'h0 && ($past(scanRow) < 4'h7 || romPattern == 8'h00))
		else $error("ROM glyph padding not blank");
endmodule
`default_nettype wire

// [tb/cgh_host_model.sv]
// Host microprocessor model driving the parallel bus pins in one of three bus families
`timescale 1ns/1ps
`default_nettype none
module cgh_host_model
(
	input  wire logic       clk_sys,
	output logic [2:0]      busTypeStraps,
	output logic            commandDataSelect,
	output logic            rdPin,
	output logic            wrPin,
	output logic [7:0]      dataIn
);
	logic active;
	logic isRd;

	// =========================================
	// Pin encoding per bus family
	always_comb
	begin
		case (busTypeStraps)
			3'h1:
			begin
				rdPin = isRd;
				wrPin = active;
			end
			3'h2:
			begin
				rdPin = isRd;
				wrPin = ~active;
			end
			default:
			begin
				rdPin = ~(active & isRd);
				wrPin = ~(active & ~isRd);
			end
		endcase
	end

	initial
	begin
		busTypeStraps = 3'h0;
		active = 1'b0;
		isRd = 1'b0;
		commandDataSelect = 1'b0;
		dataIn = 8'h00;
	end

	// =========================================
	// Bus cycles
	// Data and select settle well before the strobe and hold past its sync delay
	task automatic access(input logic sel, input logic rd, input logic [7:0] val);
		@(posedge clk_sys);
		#1;
		commandDataSelect = sel;
		isRd = rd;
		dataIn = val;
		repeat (4) @(posedge clk_sys);
		#1;
		active = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		active = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		dataIn = ~val;
	endtask

	// Straps change only while no strobe is active
	task automatic setBus(input logic [2:0] t);
		@(posedge clk_sys);
		#1;
		busTypeStraps = t;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// [tb/char_generator_host_port_tb_top.sv]
// Self-checking testbench of the character generator host port
`timescale 1ns/1ps
`default_nettype none
module char_generator_host_port_tb_top;
	logic        clk_sys;
	logic        rstn;
	logic [2:0]  busTypeStraps;
	logic        commandDataSelect;
	logic        rdPin;
	logic        wrPin;
	logic [7:0]  dataIn;
	logic [7:0]  dataOut;
	logic        dataOe;
	logic [15:0] memAddr;
	logic [7:0]  memWrData;
	logic        memWrEn;
	logic [7:0]  memRdData;
	logic        scanReq;
	logic [7:0]  scanCharCode;
	logic [3:0]  scanRow;
	logic [15:0] patternAddr;
	logic        patternFromRam;
	logic [7:0]  romPattern;
	logic        patternValid;
	logic [7:0]  displayConfig;
	logic [7:0]  memArr [0:65535];
	logic [15:0] baseExp;
	logic [7:0]  cfgExp;
	int          failures;
	int          compares;
	int          wrCount;
	int          cycles;
	int          oeCycles;

	cgh_core i_cgh_core (.clk_sys(clk_sys), .rstn(rstn), .busTypeStraps(busTypeStraps),
		.commandDataSelect(commandDataSelect), .rdPin(rdPin), .wrPin(wrPin), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .memAddr(memAddr), .memWrData(memWrData),
		.memWrEn(memWrEn), .memRdData(memRdData), .scanReq(scanReq),
		.scanCharCode(scanCharCode), .scanRow(scanRow), .patternAddr(patternAddr),
		.patternFromRam(patternFromRam), .romPattern(romPattern),
		.patternValid(patternValid), .displayConfig(displayConfig));

	cgh_host_model i_cgh_host_model (.clk_sys(clk_sys), .busTypeStraps(busTypeStraps),
		.commandDataSelect(commandDataSelect), .rdPin(rdPin), .wrPin(wrPin), .dataIn(dataIn));

	// =========================================
	// Display memory and clock
	assign memRdData = memArr[memAddr];

	always @(posedge clk_sys)
	begin
		cycles++;
		if (memWrEn === 1'b1)
		begin
			memArr[memAddr] <= memWrData;
			wrCount++;
		end
		if (cycles == 20000)
		begin
			failures++;
			end_of_test();
		end
	end

	// Read drive enable counted on the falling edge, away from its launch
	always @(negedge clk_sys)
	begin
		if (dataOe === 1'b1)
			oeCycles++;
	end

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// =========================================
	// Compare and bus helpers
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk16({8'h00, got}, {8'h00, exp});
	endtask

	task automatic cmd(input logic [7:0] v);
		i_cgh_host_model.access(1'b1, 1'b0, v);
	endtask

	task automatic dat(input logic [7:0] v);
		i_cgh_host_model.access(1'b0, 1'b0, v);
	endtask

	task automatic setBase(input logic [7:0] lo, input logic [7:0] hi);
		cmd(8'h5C);
		dat(lo);
		dat(hi);
		baseExp = {hi, lo};
	endtask

	task automatic setCfg(input logic [7:0] v);
		cmd(8'h40);
		dat(v);
		cfgExp = v;
		chk8(displayConfig, v);
	endtask

	// One fetch; expected address and source worked out from the layout tables
	task automatic scan(input logic [7:0] code, input logic [3:0] row);
		logic [15:0] off;
		logic        ram;
		off = cfgExp[2] ? {4'h0, code, row} : {5'h00, code, row[2:0]};
		ram = cfgExp[0] | (code >= 8'h80 && code <= 8'h9F) | (code >= 8'hE0);
		@(posedge clk_sys);
		#1;
		scanReq = 1'b1;
		scanCharCode = code;
		scanRow = row;
		@(posedge clk_sys);
		#1;
		scanReq = 1'b0;
		chk8({7'h00, patternValid}, 8'h01);
		chk16(patternAddr, baseExp + off);
		chk8({7'h00, patternFromRam}, {7'h00, ram});
		if (ram || row >= 4'h7 || code < 8'h20)
			chk8(romPattern, 8'h00);
		else
			chk8({5'h00, romPattern[2:0]}, 8'h00);
		@(posedge clk_sys);
		#1;
		chk8({7'h00, patternValid}, 8'h00);
	endtask

	// =========================================
	// Scenarios
	task automatic t_pattern();
		logic [7:0] codes [8];
		codes = '{8'h80, 8'h41, 8'h9F, 8'hA0, 8'hDF, 8'hE0, 8'hFF, 8'h7F};
		setBase(8'h00, 8'h40);
		setCfg(8'h00);
		foreach (codes[i])
			scan(codes[i], 4'(i));
		setCfg(8'h04);
		scan(8'h80, 4'hF);
		scan(8'hFF, 4'h9);
		setBase(8'h00, 8'h00);
		setCfg(8'h01);
		scan(8'h41, 4'h5);
	endtask

	task automatic t_fill(input logic [2:0] bus);
		logic [7:0] hi;
		int         w0;
		int         oe0;
		hi = 8'h48 + 8'(bus);
		i_cgh_host_model.setBus(bus);
		cmd(8'h46);
		dat(8'h00);
		dat(hi);
		chk16(memAddr, {hi, 8'h00});
		cmd(8'h4C);
		cmd(8'h42);
		w0 = wrCount;
		dat(8'h70);
		dat(8'h88);
		chk8(memArr[{hi, 8'h00}], 8'h70);
		chk8(memArr[{hi, 8'h01}], 8'h88);
		chk16(memAddr, {hi, 8'h02});
		memArr[{hi, 8'h02}] = 8'hA5 ^ hi;
		memArr[{hi, 8'h03}] = 8'h5A ^ hi;
		oe0 = oeCycles;
		i_cgh_host_model.access(1'b1, 1'b1, 8'h00);
		chk8(dataOut, 8'hA5 ^ hi);
		chk16(memAddr, {hi, 8'h03});
		chk16(16'(oeCycles - oe0), 16'h0006);
		oe0 = oeCycles;
		i_cgh_host_model.access(1'b0, 1'b1, 8'h00);
		chk16(memAddr, {hi, 8'h03});
		chk16(16'(wrCount - w0), 16'h0002);
		chk8(dataOut, 8'hA5 ^ hi);
		chk16(16'(oeCycles - oe0), 16'h0000);
		cmd(8'h4D);
		i_cgh_host_model.access(1'b1, 1'b1, 8'h00);
		chk8(dataOut, 8'h5A ^ hi);
		chk16(memAddr, {hi, 8'h02});
	endtask

	task automatic end_of_test();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		rstn = 1'b0;
		scanReq = 1'b0;
		scanCharCode = 8'h00;
		scanRow = 4'h0;
		failures = 0;
		compares = 0;
		wrCount = 0;
		cycles = 0;
		oeCycles = 0;
		baseExp = 16'h0000;
		cfgExp = 8'h00;
		repeat (2) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		chk8(displayConfig, 8'h00);
		chk16(memAddr, 16'h0000);
		t_pattern();
		t_fill(3'h0);
		t_fill(3'h1);
		t_fill(3'h2);
		end_of_test();
	end
endmodule
`default_nettype wire
